// ===== design/dphyr_pkg.sv
// Summary of operation
// - Every low-power state lasts 50 ns; only the LP-01 and LP-00 of HS entry are checked against it
// - Data termination enabled quickly on LP-00
// - Ignore lane during end-of-transmission skip
// - Detect stopped clock lane within 60 ns
// - Clock termination enabled within 38 ns
// - Unit interval is half link clock
package dphyr_pkg;

   // ==========================================================
   // Clock and counter widths
   localparam int CLK_PERIOD_NS = 4;
   localparam int CNT_W = 12;
   // Core reset stretched for the link side; covers several slow link periods
   localparam int T_LINK_RST_NS = 1000;
   localparam logic [CNT_W-1:0] LINK_RST_CYC = CNT_W'(T_LINK_RST_NS / CLK_PERIOD_NS);
   // Link divider: one toggle per 8 link edges, so 16 UI between flips
   localparam int UI_DIV_W = 3;

   // ==========================================================
   // Times as printed, in ns
   localparam int LOW_POWER_STATE_PERIOD_NS = 50;
   localparam int T_SKIP_MIN_NS = 40;
   localparam int T_EXIT_NS = 100;
   localparam int T_GAP_NS = 150;
   localparam int T_CLK_MISS_NS = 60;
   localparam int T_TERM_EN_NS = 35;
   localparam int T_CLK_TERM_NS = 38;

   // ==========================================================
   // Cycle counts: least times round up, longest times round down
   localparam logic [CNT_W-1:0] LPX_CYC =
      CNT_W'((LOW_POWER_STATE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SKIP_CYC =
      CNT_W'((T_SKIP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] EXIT_CYC =
      CNT_W'((T_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] GAP_CYC =
      CNT_W'((T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int CLK_MISS_CYC = T_CLK_MISS_NS / CLK_PERIOD_NS;
   localparam int TERM_EN_CYC = T_TERM_EN_NS / CLK_PERIOD_NS;
   localparam int CLK_TERM_CYC = T_CLK_TERM_NS / CLK_PERIOD_NS;

   // ==========================================================
   // Line states as {p, n}
   localparam logic [1:0] LS_LP00 = 2'h0;
   localparam logic [1:0] LS_LP01 = 2'h1;
   localparam logic [1:0] LS_LP10 = 2'h2;
   localparam logic [1:0] LS_LP11 = 2'h3;

   // ==========================================================
   // Data lane sequencer states
   typedef enum logic [2:0] {
      ST_STOP,
      ST_HS_REQ,
      ST_PREP,
      ST_HS,
      ST_SKIP,
      ST_ESC
   } dphyr_lane_state_type;

endpackage : dphyr_pkg

// ===== design/dphyr_sync.sv
`timescale 1ns/1ps
module dphyr_sync #(
   parameter int W = 1
) (
   // Destination clock
   input wire logic i_clk,
   // Asynchronous levels in, synchronised levels out
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   // ==========================================================
   // Two-stage synchroniser; no reset so it can also carry a reset
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   always_ff @(posedge i_clk)
   begin
      meta_r <= i_d;
      q_r <= meta_r;
   end

   assign o_q = q_r;

endmodule : dphyr_sync

// ===== design/dphyr_lane_timing_receiver.sv
`timescale 1ns/1ps
module dphyr_lane_timing_receiver (
   // Core clock and reset
   input wire logic i_core_clk,
   input wire logic i_srst,
   // Forwarded high-speed clock from the clock lane
   input wire logic i_hs_clk,
   // Low-power line receivers
   input wire logic i_dat_lp_p,
   input wire logic i_dat_lp_n,
   input wire logic i_clk_lp_p,
   input wire logic i_clk_lp_n,
   // Data lane control
   output logic o_dat_term_en,
   output logic o_dat_hs_rx_en,
   output logic o_eot_skip,
   // Clock lane control and status
   output logic o_clk_term_en,
   output logic o_clk_stopped,
   // Timing violation pulses
   output logic o_gap_err,
   output logic o_lpx_err,
   // Measured unit interval and link-side enable
   output logic [dphyr_pkg::CNT_W-1:0] o_ui_x16,
   output logic o_link_hs_en
);

   // ==========================================================
   // Pin synchronisers
   logic [3:0] pin_s;
   logic [1:0] dat_ls;
   logic [1:0] clk_ls;

   dphyr_sync #(.W(4)) u_pin_sync (
      .i_clk(i_core_clk),
      .i_d({i_dat_lp_p, i_dat_lp_n, i_clk_lp_p, i_clk_lp_n}),
      .o_q(pin_s)
   );

   assign dat_ls = pin_s[3:2];
   assign clk_ls = pin_s[1:0];

   // ==========================================================
   // Link domain: reset crossing and UI divider toggle
   logic [1:0] link_s;
   logic link_rst;
   logic [dphyr_pkg::CNT_W-1:0] lrst_cnt_r;
   logic [dphyr_pkg::CNT_W-1:0] lrst_cnt_nxt;
   logic lrst_req_r;
   logic lrst_req_nxt;
   logic [dphyr_pkg::UI_DIV_W-1:0] div_r;
   logic [dphyr_pkg::UI_DIV_W-1:0] div_nxt;
   logic tog_r;
   logic tog_nxt;
   logic hsrx_r;

   dphyr_sync #(.W(2)) u_link_sync (
      .i_clk(i_hs_clk),
      .i_d({lrst_req_r, hsrx_r}),
      .o_q(link_s)
   );

   // A short core reset can fall between two slow link edges, so stretch it
   always_comb
   begin
      lrst_cnt_nxt = (lrst_cnt_r == '0) ? lrst_cnt_r : lrst_cnt_r - 1'b1;
      lrst_req_nxt = lrst_cnt_r != '0;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         lrst_cnt_r <= dphyr_pkg::LINK_RST_CYC;
         lrst_req_r <= 1'b1;
      end
      else
      begin
         lrst_cnt_r <= lrst_cnt_nxt;
         lrst_req_r <= lrst_req_nxt;
      end
   end

   assign link_rst = link_s[1];
   assign o_link_hs_en = link_s[0];

   always_comb
   begin
      div_nxt = div_r + 1'b1;
      tog_nxt = tog_r ^ (&div_r);
   end

   // Link clock may stop; the core only ever sees a level from here
   always_ff @(posedge i_hs_clk)
   begin
      if (link_rst)
      begin
         div_r <= '0;
         tog_r <= 1'b0;
      end
      else
      begin
         div_r <= div_nxt;
         tog_r <= tog_nxt;
      end
   end

   // ==========================================================
   // Unit interval measurement in core cycles per 16 UI
   logic tog_s;
   logic tog_d_r;
   logic tog_edge;
   logic [dphyr_pkg::CNT_W-1:0] ui_cnt_r;
   logic [dphyr_pkg::CNT_W-1:0] ui_cnt_nxt;
   logic [dphyr_pkg::CNT_W-1:0] ui_r;
   logic [dphyr_pkg::CNT_W-1:0] ui_nxt;
   logic ui_seen_r;
   logic ui_seen_nxt;

   dphyr_sync #(.W(1)) u_tog_sync (
      .i_clk(i_core_clk),
      .i_d(tog_r),
      .o_q(tog_s)
   );

   // Toggle is not trusted while the link side is still held in reset
   assign tog_edge = (tog_s ^ tog_d_r) && !lrst_req_r;

   always_comb
   begin
      ui_nxt = ui_r;
      ui_seen_nxt = ui_seen_r;
      ui_cnt_nxt = (&ui_cnt_r) ? ui_cnt_r : ui_cnt_r + 1'b1;
      if (tog_edge)
      begin
         // First interval after reset is partial, so it is not kept
         ui_seen_nxt = 1'b1;
         if (ui_seen_r)
         begin
            ui_nxt = ui_cnt_r;
         end
         ui_cnt_nxt = dphyr_pkg::CNT_W'(1);
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         tog_d_r <= 1'b0;
         ui_cnt_r <= '0;
         ui_r <= '0;
         ui_seen_r <= 1'b0;
      end
      else
      begin
         tog_d_r <= tog_s;
         ui_cnt_r <= ui_cnt_nxt;
         ui_r <= ui_nxt;
         ui_seen_r <= ui_seen_nxt;
      end
   end

   assign o_ui_x16 = ui_r;

   // ==========================================================
   // Data lane sequencer
   dphyr_pkg::dphyr_lane_state_type state_r;
   dphyr_pkg::dphyr_lane_state_type state_nxt;
   logic [dphyr_pkg::CNT_W-1:0] cnt_r;
   logic [dphyr_pkg::CNT_W-1:0] cnt_nxt;
   logic [dphyr_pkg::CNT_W-1:0] stop_r;
   logic [dphyr_pkg::CNT_W-1:0] stop_nxt;
   logic last_hs_r;
   logic last_hs_nxt;
   logic gap_err_r;
   logic gap_err_nxt;
   logic lpx_err_r;
   logic lpx_err_nxt;
   logic term_r;
   logic skip_r;
   logic [dphyr_pkg::CNT_W:0] ui2;
   logic [dphyr_pkg::CNT_W:0] need_hs;
   logic [dphyr_pkg::CNT_W:0] need_lp;

   // 32 UI is twice the 16 UI measurement
   assign ui2 = {ui_r, 1'b0};
   assign need_hs = (ui2 > {1'b0, dphyr_pkg::GAP_CYC}) ? ui2 : {1'b0, dphyr_pkg::GAP_CYC};
   assign need_lp = last_hs_r ? need_hs : {1'b0, dphyr_pkg::GAP_CYC};

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = (&cnt_r) ? cnt_r : cnt_r + 1'b1;
      stop_nxt = stop_r;
      last_hs_nxt = last_hs_r;
      gap_err_nxt = 1'b0;
      lpx_err_nxt = 1'b0;
      case (state_r)
         dphyr_pkg::ST_STOP:
         begin
            if (dat_ls == dphyr_pkg::LS_LP11)
            begin
               stop_nxt = (&stop_r) ? stop_r : stop_r + 1'b1;
            end
            else
            begin
               cnt_nxt = dphyr_pkg::CNT_W'(1);
               stop_nxt = '0;
               if (dat_ls == dphyr_pkg::LS_LP01)
               begin
                  state_nxt = dphyr_pkg::ST_HS_REQ;
                  gap_err_nxt = {1'b0, stop_r} < need_hs;
               end
               else
               begin
                  state_nxt = dphyr_pkg::ST_ESC;
                  gap_err_nxt = {1'b0, stop_r} < need_lp;
               end
            end
         end
         dphyr_pkg::ST_HS_REQ:
         begin
            if (dat_ls != dphyr_pkg::LS_LP01)
            begin
               lpx_err_nxt = cnt_r < dphyr_pkg::LPX_CYC;
               cnt_nxt = dphyr_pkg::CNT_W'(1);
               if (dat_ls == dphyr_pkg::LS_LP00)
               begin
                  state_nxt = dphyr_pkg::ST_PREP;
               end
               else if (dat_ls == dphyr_pkg::LS_LP11)
               begin
                  state_nxt = dphyr_pkg::ST_STOP;
                  stop_nxt = dphyr_pkg::CNT_W'(1);
               end
               else
               begin
                  state_nxt = dphyr_pkg::ST_ESC;
               end
            end
         end
         dphyr_pkg::ST_PREP:
         begin
            // HS receiver waits out one full low-power period of LP-00
            if (dat_ls != dphyr_pkg::LS_LP00)
            begin
               lpx_err_nxt = 1'b1;
               cnt_nxt = dphyr_pkg::CNT_W'(1);
               state_nxt = (dat_ls == dphyr_pkg::LS_LP11) ? dphyr_pkg::ST_STOP
                                                         : dphyr_pkg::ST_ESC;
               stop_nxt = dphyr_pkg::CNT_W'(1);
            end
            else if (cnt_r >= dphyr_pkg::LPX_CYC)
            begin
               state_nxt = dphyr_pkg::ST_HS;
            end
         end
         dphyr_pkg::ST_HS:
         begin
            last_hs_nxt = 1'b1;
            if (dat_ls == dphyr_pkg::LS_LP11)
            begin
               state_nxt = dphyr_pkg::ST_SKIP;
               cnt_nxt = dphyr_pkg::CNT_W'(1);
            end
         end
         dphyr_pkg::ST_SKIP:
         begin
            // Line is not examined here; trailing glitches must not restart a burst
            if (cnt_r >= dphyr_pkg::SKIP_CYC)
            begin
               state_nxt = dphyr_pkg::ST_STOP;
               stop_nxt = cnt_r;
            end
         end
         default:
         begin
            last_hs_nxt = 1'b0;
            if (dat_ls == dphyr_pkg::LS_LP11)
            begin
               state_nxt = dphyr_pkg::ST_STOP;
               stop_nxt = dphyr_pkg::CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         state_r <= dphyr_pkg::ST_STOP;
         cnt_r <= '0;
         stop_r <= '0;
         last_hs_r <= 1'b0;
         gap_err_r <= 1'b0;
         lpx_err_r <= 1'b0;
         term_r <= 1'b0;
         hsrx_r <= 1'b0;
         skip_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         stop_r <= stop_nxt;
         last_hs_r <= last_hs_nxt;
         gap_err_r <= gap_err_nxt;
         lpx_err_r <= lpx_err_nxt;
         term_r <= (state_nxt == dphyr_pkg::ST_PREP) || (state_nxt == dphyr_pkg::ST_HS);
         hsrx_r <= state_nxt == dphyr_pkg::ST_HS;
         skip_r <= state_nxt == dphyr_pkg::ST_SKIP;
      end
   end

   assign o_dat_term_en = term_r;
   assign o_dat_hs_rx_en = hsrx_r;
   assign o_eot_skip = skip_r;
   assign o_gap_err = gap_err_r;
   assign o_lpx_err = lpx_err_r;

   // ==========================================================
   // Clock lane termination and stop detection
   logic clk_hs_r;
   logic clk_hs_nxt;
   logic clk_stop_r;

   always_comb
   begin
      clk_hs_nxt = clk_hs_r;
      if (clk_ls == dphyr_pkg::LS_LP00)
      begin
         clk_hs_nxt = 1'b1;
      end
      else if (clk_ls == dphyr_pkg::LS_LP11)
      begin
         clk_hs_nxt = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         clk_hs_r <= 1'b0;
         clk_stop_r <= 1'b1;
      end
      else
      begin
         clk_hs_r <= clk_hs_nxt;
         clk_stop_r <= clk_ls == dphyr_pkg::LS_LP11;
      end
   end

   assign o_clk_term_en = clk_hs_r;
   assign o_clk_stopped = clk_stop_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);

   property p_dat_term;
      (state_r == dphyr_pkg::ST_HS_REQ && dat_ls == dphyr_pkg::LS_LP00) |=> o_dat_term_en;
   endproperty
   a_dat_term: assert property (p_dat_term) else $error("data termination late");

   property p_clk_term;
      (clk_ls == dphyr_pkg::LS_LP00) |=> o_clk_term_en;
   endproperty
   a_clk_term: assert property (p_clk_term) else $error("clock termination late");

   property p_skip_len;
      $rose(o_eot_skip) |-> o_eot_skip [*8] ##1 o_eot_skip ##1 o_eot_skip ##1 !o_eot_skip;
   endproperty
   a_skip_len: assert property (p_skip_len) else $error("skip window wrong length");

   property p_clk_stop;
      $rose(i_clk_lp_p && i_clk_lp_n) ##1 (i_clk_lp_p && i_clk_lp_n) [*2]
         |-> ##[0:3] o_clk_stopped;
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("clock stop not seen");

   property p_gap_short;
      (state_r == dphyr_pkg::ST_STOP && dat_ls != dphyr_pkg::LS_LP11
         && stop_r < dphyr_pkg::GAP_CYC) |=> o_gap_err;
   endproperty
   a_gap_short: assert property (p_gap_short) else $error("short gap not flagged");

   property p_gap_ok;
      (state_r == dphyr_pkg::ST_STOP && dat_ls == dphyr_pkg::LS_LP01
         && {1'b0, stop_r} >= ui2 && stop_r >= dphyr_pkg::GAP_CYC) |=> !o_gap_err;
   endproperty
   a_gap_ok: assert property (p_gap_ok) else $error("good gap flagged");

   property p_exit;
      (state_r == dphyr_pkg::ST_STOP && dat_ls != dphyr_pkg::LS_LP11 && last_hs_r
         && stop_r < dphyr_pkg::EXIT_CYC) |=> o_gap_err;
   endproperty
   a_exit: assert property (p_exit) else $error("short burst exit missed");

   property p_prep_len;
      $rose(o_dat_hs_rx_en) |-> $past(o_dat_term_en, 13) && !$past(o_dat_term_en, 14);
   endproperty
   a_prep_len: assert property (p_prep_len) else $error("prepare wait wrong");

   property p_order;
      o_dat_hs_rx_en |-> o_dat_term_en && !o_eot_skip;
   endproperty
   a_order: assert property (p_order) else $error("receiver on out of order");

   property p_ui;
      $changed(o_ui_x16) |-> $past(tog_edge);
   endproperty
   a_ui: assert property (p_ui) else $error("unit interval changed without edge");

   c_burst: cover property ($fell(o_eot_skip) ##0 last_hs_r);
   c_gap: cover property (o_gap_err);
   c_lpx: cover property (o_lpx_err);
   c_clk: cover property ($rose(o_clk_stopped));

endmodule : dphyr_lane_timing_receiver

// ===== dv/dphyr_host_model.sv
`timescale 1ns/1ps
module dphyr_host_model (
   // Data lane low-power levels
   output logic o_dat_lp_p,
   output logic o_dat_lp_n,
   // Clock lane low-power levels
   output logic o_clk_lp_p,
   output logic o_clk_lp_n,
   // Forwarded high-speed clock
   output logic o_hs_clk
);
   // ==========================================
   // Link clock
   logic run;
   // Free running while the clock lane is in HS; held low once stopped
   initial
   begin
      run = 1'b1;
      o_hs_clk = 1'b0;
      forever #62.5 o_hs_clk = run ? ~o_hs_clk : 1'b0;
   end
   // ==========================================
   // Lane levels
   initial
   begin
      {o_dat_lp_p, o_dat_lp_n} = dphyr_pkg::LS_LP11;
      {o_clk_lp_p, o_clk_lp_n} = dphyr_pkg::LS_LP00;
   end
   // Callers hold each level for a chosen number of cycles, some shorter than one low-power period
   task automatic set_dat(input logic [1:0] s);
      {o_dat_lp_p, o_dat_lp_n} = s;
   endtask : set_dat
   task automatic set_clk(input logic [1:0] s, input logic r);
      {o_clk_lp_p, o_clk_lp_n} = s;
      run = r;
   endtask : set_clk
endmodule : dphyr_host_model

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
   typedef struct {int gap; logic [1:0] s1; int t1; int t2; logic [3:0] e;} dphyr_row_type;
   logic clk;
   logic srst;
   wire dlp, dln, clp, cln, hsclk;
   logic term, hsrx, skip, cterm, cstop, gerr, lerr, lhs;
   logic [dphyr_pkg::CNT_W-1:0] ui;
   int fail_count;
   int comparisons;
   logic sg, sl, sh, sk;
   int nskip;
   int tdly;
   dphyr_row_type rows [7];
   // ==========================================
   // Instances
   dphyr_host_model host (.o_dat_lp_p(dlp), .o_dat_lp_n(dln), .o_clk_lp_p(clp),
      .o_clk_lp_n(cln), .o_hs_clk(hsclk));
   dphyr_lane_timing_receiver uut (.i_core_clk(clk), .i_srst(srst), .i_hs_clk(hsclk),
      .i_dat_lp_p(dlp), .i_dat_lp_n(dln), .i_clk_lp_p(clp), .i_clk_lp_n(cln),
      .o_dat_term_en(term), .o_dat_hs_rx_en(hsrx), .o_eot_skip(skip),
      .o_clk_term_en(cterm), .o_clk_stopped(cstop), .o_gap_err(gerr),
      .o_lpx_err(lerr), .o_ui_x16(ui), .o_link_hs_en(lhs));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ==========================================
   // Helpers
   task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic results();
      $display("Mismatches %0d of %0d comparisons", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   // Hold one data lane level for n cycles and gather what the outputs did
   task automatic phase(input logic [1:0] s, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         #1;
         sg |= (gerr === 1'b1);
         sl |= (lerr === 1'b1);
         sh |= (hsrx === 1'b1);
         sk |= (lhs === 1'b1);
         nskip += (skip === 1'b1);
         if (s == dphyr_pkg::LS_LP00 && tdly < 0 && term === 1'b1)
            tdly = i;
         if (i == 0)
            host.set_dat(s);
      end
   endtask : phase
   task automatic clr();
      {sg, sl, sh, sk} = 4'h0;
      nskip = 0;
      tdly = -1;
   endtask : clr
   // Bounded wait on a clock lane output; a spent bound ends the run
   task automatic await_c(input logic want_stop, input int lim, output int n);
      for (n = 0; n < lim; n++)
      begin
         @(posedge clk);
         #1;
         if ((want_stop ? cstop : cterm) === 1'b1)
            break;
      end
      if (n == lim)
      begin
         fail_count++;
         results();
      end
   endtask : await_c
   // ==========================================
   // Sequence
   initial
   begin : main
      int n;
      srst = 1'b1;
      fail_count = 0;
      comparisons = 0;
      clr();
      repeat (8) @(posedge clk);
      #1;
      check("rst_outs", 12'({term, hsrx, skip, cterm, cstop, gerr, lerr}), 12'h004);
      check("rst_ui", ui, 12'h000);
      srst = 1'b0;
      // gap, first state, its cycles, LP-00 cycles, {gap_err, lpx_err, hs_en, term}
      rows[0] = '{600, dphyr_pkg::LS_LP01, 20, 200, 4'h3};
      rows[1] = '{100, dphyr_pkg::LS_LP01, 20, 200, 4'hb};
      rows[2] = '{600, dphyr_pkg::LS_LP01, 8, 200, 4'h7};
      rows[3] = '{600, dphyr_pkg::LS_LP01, 20, 8, 4'h5};
      rows[4] = '{600, dphyr_pkg::LS_LP10, 20, 0, 4'h0};
      rows[5] = '{10, dphyr_pkg::LS_LP10, 20, 0, 4'h8};
      rows[6] = '{60, dphyr_pkg::LS_LP10, 20, 0, 4'h0};
      foreach (rows[k])
      begin
         phase(dphyr_pkg::LS_LP11, rows[k].gap);
         clr();
         phase(rows[k].s1, rows[k].t1);
         phase(dphyr_pkg::LS_LP00, rows[k].t2);
         phase(dphyr_pkg::LS_LP11, 16);
         check("gap_err", 12'(sg), 12'(rows[k].e[3]));
         check("lpx_err", 12'(sl), 12'(rows[k].e[2]));
         check("hs_rx_en", 12'(sh), 12'(rows[k].e[1]));
         check("term_seen", 12'(tdly >= 0), 12'(rows[k].e[0]));
         if (rows[k].e[0])
            check("term_dly", 12'(tdly <= 8), 12'h001);
         if (rows[k].e[1])
         begin
            check("eot_skip", 12'(nskip), 12'h00a);
            check("link_hs_en", 12'(sk), 12'h001);
         end
      end
      check("ui_x16", 12'(ui >= 249 && ui <= 251), 12'h001);
      // Line activity inside the skip window must be ignored
      phase(dphyr_pkg::LS_LP11, 600);
      phase(dphyr_pkg::LS_LP01, 20);
      phase(dphyr_pkg::LS_LP00, 200);
      clr();
      phase(dphyr_pkg::LS_LP11, 4);
      phase(dphyr_pkg::LS_LP01, 2);
      phase(dphyr_pkg::LS_LP11, 100);
      check("skip_glitch", 12'({sg, sl}), 12'h000);
      check("skip_len", 12'(nskip), 12'h00a);
      // Clock lane stop and restart
      check("clk_run", 12'({cstop, cterm}), 12'h001);
      host.set_clk(dphyr_pkg::LS_LP11, 1'b0);
      await_c(1'b1, 40, n);
      check("clk_miss", 12'(n <= 15), 12'h001);
      check("clk_term_off", 12'(cterm), 12'h000);
      host.set_clk(dphyr_pkg::LS_LP00, 1'b1);
      await_c(1'b0, 40, n);
      check("clk_term_dly", 12'(n <= 9), 12'h001);
      // Mid-run reset with the clock lane in LP-00
      srst = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check("rst_mid", 12'({term, hsrx, skip, cterm, cstop, gerr, lerr}), 12'h004);
      srst = 1'b0;
      results();
   end
endmodule : tb
